/* File: src/dlam_pkg.sv */
package dlam_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_HZ       = 25000000;
  localparam int TICK_MS      = 10;
  localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int TS_UNIT_MS   = 100;
  localparam int TS_UNIT_TICK = TS_UNIT_MS / TICK_MS;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG    = 8'h00;
  localparam logic [7:0] ADDR_SCALE  = 8'h04;
  localparam logic [7:0] ADDR_HYST   = 8'h08;
  localparam logic [7:0] ADDR_SETPT  = 8'h0C;
  localparam logic [7:0] ADDR_TSTART = 8'h10;
  localparam logic [7:0] ADDR_TREAC1 = 8'h14;
  localparam logic [7:0] ADDR_TREAC2 = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_PEAK   = 8'h20;

  // --------------------------------------------------------------------------
  // Encodings and ranges
  // --------------------------------------------------------------------------
  localparam logic [1:0]  LIM_OFF   = 2'h0;
  localparam logic [1:0]  LIM_MIN   = 2'h1;
  localparam logic [1:0]  LIM_MAX   = 2'h2;
  localparam logic [7:0]  START_PCT = 8'h05;
  localparam logic [7:0]  ZERO_4MA  = 8'h28;
  localparam logic [15:0] SP_LO     = 16'h0005;
  localparam logic [15:0] SP_HI     = 16'h0063;
  localparam logic [15:0] TS_HI     = 16'h2706;
  localparam logic [15:0] TR_HI     = 16'hFFDC;
  localparam logic [15:0] FS_LO     = 16'h0064;
  localparam logic [15:0] FS_HI     = 16'h00C8;
  localparam logic [15:0] HYS_HI    = 16'h0032;
  localparam logic [3:0]  PAR_LAST  = 4'hB;

  typedef struct packed {
    logic        span4;
    logic [1:0]  type1;
    logic [1:0]  type2;
    logic [7:0]  fs;
    logic [5:0]  hys1;
    logic [5:0]  hys2;
    logic        inv1;
    logic        inv2;
    logic        autosd;
    logic        logic_hi;
    logic        lock;
    logic [6:0]  sp1;
    logic [6:0]  sp2;
    logic [13:0] ts;
    logic [15:0] tr1;
    logic [15:0] tr2;
  } dlam_cfg_t;

  localparam dlam_cfg_t CFG_RST = '{1'b0, LIM_MAX, LIM_MIN, 8'hC8, 6'h00,
      6'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 7'h50, 7'h14, 14'h0014,
      16'h000A, 16'h0064};

  typedef enum logic [2:0] {ST_INPUT, ST_TS, ST_SP1, ST_SP2, ST_TR1,
                            ST_TR2, ST_SETUP, ST_EDIT} dlam_menu_t;
  typedef enum logic [1:0] {SU_WAIT, SU_RUN, SU_DONE} dlam_su_t;
  typedef enum logic [1:0] {VW_PCT, VW_MAX, VW_MIN} dlam_view_t;

endpackage : dlam_pkg

/* File: src/dlam_if.sv */
`timescale 1ns/100ps

interface dlam_lim_if;
  logic [1:0]  ltype;
  logic [6:0]  setpt;
  logic [5:0]  hyst;
  logic [15:0] delay;
  logic [7:0]  pct;
  logic        tick;
  logic        mon_en;
  logic        autosd;
  logic        block;
  logic        clear;
  logic        alarm;
  modport ctrl (output ltype, setpt, hyst, delay, pct, tick, mon_en,
                autosd, block, clear, input alarm);
  modport lim  (input ltype, setpt, hyst, delay, pct, tick, mon_en,
                autosd, block, clear, output alarm);
endinterface : dlam_lim_if

interface dlam_reg_if;
  logic        wr;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;
  modport bus  (output wr, addr, wdata, input rdata, hit);
  modport regs (input wr, addr, wdata, output rdata, hit);
endinterface : dlam_reg_if

/* File: src/dlam_apb.sv */
`timescale 1ns/100ps

module dlam_apb (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  dlam_reg_if.bus          rif
);
  logic [31:0] rd_q;
  logic [31:0] rd_d;

  // Read data is captured in the setup cycle, so the access is zero-wait.
  always_comb begin
    rd_d = rd_q;
    if (psel && !penable) begin
      rd_d = rif.hit ? rif.rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q <= 32'h0000_0000;
    end else if (ce) begin
      rd_q <= rd_d;
    end
  end

  assign rif.addr  = paddr;
  assign rif.wdata = pwdata;
  assign rif.wr    = ce && psel && penable && pwrite && rif.hit;
  assign prdata    = rd_q;
  assign pready    = ce;
  assign pslverr   = psel && penable && !rif.hit;

endmodule : dlam_apb

/* File: src/dlam_limit.sv */
`timescale 1ns/100ps

module dlam_limit
  import dlam_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic ce,
  dlam_lim_if.lim   lif
);
  logic        viol;
  logic        back_in;
  logic [8:0]  wide_pct;
  logic [8:0]  wide_sp;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        alarm_q;
  logic        alarm_d;

  always_comb begin
    wide_pct = {1'b0, lif.pct};
    wide_sp  = {2'b00, lif.setpt};
    viol     = 1'b0;
    back_in  = 1'b0;
    if (lif.ltype == LIM_MIN) begin
      viol    = wide_pct < wide_sp && !(lif.autosd && lif.pct == 8'h00);
      back_in = wide_pct > 9'(wide_sp + {3'b000, lif.hyst});
    end else if (lif.ltype == LIM_MAX) begin
      viol    = wide_pct > wide_sp;
      back_in = 9'(wide_pct + {3'b000, lif.hyst}) < wide_sp;
    end
    if (lif.block) begin
      viol = 1'b0;
    end
    cnt_d   = cnt_q;
    alarm_d = alarm_q;
    if (!lif.mon_en) begin
      cnt_d   = 16'h0000;
      alarm_d = 1'b0;
    end else begin
      if (!viol) begin
        cnt_d = 16'h0000;
      end else if (lif.tick && cnt_q < lif.delay) begin
        cnt_d = 16'(cnt_q + 16'h0001);
      end
      if (lif.clear || (lif.hyst != 6'h00 && back_in)) begin
        alarm_d = 1'b0;
      end
      if (viol && cnt_q >= lif.delay) begin
        alarm_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q   <= 16'h0000;
      alarm_q <= 1'b0;
    end else if (ce) begin
      cnt_q   <= cnt_d;
      alarm_q <= alarm_d;
    end
  end

  assign lif.alarm = alarm_q && !lif.block;

endmodule : dlam_limit

/* File: src/dlam_top.sv */
// Behaviour
// - Mode presses cycle the displays; the setup state opens at slot zero.
// - Up/down pick a slot, mode opens it, up/down edit, mode stores.
// - Mode on slot zero leaves the menu and returns to the input view.
// - Slot one picks a zero or four milliampere span, zero by default.
// - Slots two and three set limit types; defaults maximum and minimum.
// - Slot four sets full scale 10 to 20 mA; percent uses that span.
// - Slots five and six set hysteresis; hysteresis turns on auto-reset.
// - Band sits above a minimum and below a maximum; clears past band.
// - Slots seven and eight invert relay drive; default energises on alarm.
// - Auto shut-down suppresses minimum alarms while the input reads zero.
// - The blocking input suppresses alarm outputs while asserted.
// - Slot ten sets digital input active level, low by default.
// - Lock lets values be viewed but refuses every button edit; register writes still change values.
// - Direct values are edited with up/down; setpoints 5 to 99 percent.
// - Above five percent the start-up timer runs and blanks monitoring.
// - Each limit waits its reaction delay before raising its alarm.
// - Peaks are tracked; up or down in input view shows them.
// - Peaks clear on timer expiry; up or down with mode clears one.
// - Mode press or external reset input clears latched alarms.
// - A zero start-up time disables blanking.
`timescale 1ns/100ps

module dlam_top
  import dlam_pkg::*;
#(
  parameter int TICK_CYC_P = TICK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        btn_mode,
  input  wire logic        btn_up,
  input  wire logic        btn_down,
  input  wire logic [7:0]  in_cur,
  input  wire logic        external_reset_input,
  input  wire logic        alarm_block_input,
  output logic             relay1,
  output logic             relay2,
  output logic             setup_led,
  output logic      [2:0]  disp_sel,
  output logic      [15:0] disp_val
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [15:0] step(logic [15:0] v, logic up, logic dn,
                                       logic [15:0] lo, logic [15:0] hi);
    if (up && v < hi) begin
      step = 16'(v + 16'h0001);
    end else if (dn && v > lo) begin
      step = 16'(v - 16'h0001);
    end else begin
      step = v;
    end
  endfunction : step

  function automatic logic [15:0] par_hi(logic [3:0] n);
    unique case (n)
      4'h2, 4'h3: par_hi = 16'h0002;
      4'h4:       par_hi = FS_HI;
      4'h5, 4'h6: par_hi = HYS_HI;
      default:    par_hi = 16'h0001;
    endcase
  endfunction : par_hi

  function automatic logic [15:0] par_get(dlam_cfg_t c, logic [3:0] n);
    par_get = 16'h0000;
    unique case (n)
      4'h1: par_get[0]   = c.span4;
      4'h2: par_get[1:0] = c.type1;
      4'h3: par_get[1:0] = c.type2;
      4'h4: par_get[7:0] = c.fs;
      4'h5: par_get[5:0] = c.hys1;
      4'h6: par_get[5:0] = c.hys2;
      4'h7: par_get[0]   = c.inv1;
      4'h8: par_get[0]   = c.inv2;
      4'h9: par_get[0]   = c.autosd;
      4'hA: par_get[0]   = c.logic_hi;
      4'hB: par_get[0]   = c.lock;
      default: par_get   = 16'h0000;
    endcase
  endfunction : par_get

  function automatic dlam_cfg_t par_set(dlam_cfg_t c, logic [3:0] n,
                                        logic [15:0] v);
    par_set = c;
    unique case (n)
      4'h1: par_set.span4    = v[0];
      4'h2: par_set.type1    = v[1:0];
      4'h3: par_set.type2    = v[1:0];
      4'h4: par_set.fs       = v[7:0];
      4'h5: par_set.hys1     = v[5:0];
      4'h6: par_set.hys2     = v[5:0];
      4'h7: par_set.inv1     = v[0];
      4'h8: par_set.inv2     = v[0];
      4'h9: par_set.autosd   = v[0];
      4'hA: par_set.logic_hi = v[0];
      4'hB: par_set.lock     = v[0];
      default: par_set       = c;
    endcase
  endfunction : par_set

  function automatic logic [7:0] pct_of(logic [7:0] cur, logic span4,
                                        logic [7:0] fs);
    logic [7:0]  zero;
    logic [15:0] num;
    logic [15:0] q;
    zero = span4 ? ZERO_4MA : 8'h00;
    num  = 16'(16'(cur - zero) * 16'h0064);
    q    = num / {8'h00, 8'(fs - zero)};
    if (cur <= zero) begin
      pct_of = 8'h00;
    end else if (q > 16'h00FF) begin
      pct_of = 8'hFF;
    end else begin
      pct_of = q[7:0];
    end
  endfunction : pct_of

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  dlam_reg_if rif ();
  dlam_lim_if lif1 ();
  dlam_lim_if lif2 ();

  dlam_cfg_t   cfg_q;
  dlam_cfg_t   cfg_d;
  dlam_menu_t  st_q;
  dlam_menu_t  st_d;
  dlam_view_t  vw_q;
  dlam_view_t  vw_d;
  dlam_su_t    su_q;
  dlam_su_t    su_d;
  logic [3:0]  pn_q;
  logic [3:0]  pn_d;
  logic [15:0] ed_q;
  logic [15:0] ed_d;
  logic [17:0] tk_q;
  logic [17:0] tk_d;
  logic [17:0] ts_cnt_q;
  logic [17:0] ts_cnt_d;
  logic [7:0]  pct_q;
  logic [7:0]  max_q;
  logic [7:0]  max_d;
  logic [7:0]  min_q;
  logic [7:0]  min_d;
  logic        rly1_q;
  logic        rly2_q;
  logic        led_q;
  logic [15:0] dv_q;
  logic [15:0] dv_d;
  logic        tick;
  logic        adj;
  logic        clr_alarm;
  logic        clr_max;
  logic        clr_min;
  logic        expired;
  logic        blk_act;
  logic        rst_act;

  dlam_apb u_apb (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .rif      (rif.bus)
  );

  dlam_limit u_lim1 (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
                     .lif(lif1.lim));
  dlam_limit u_lim2 (.core_clk(core_clk), .rst_b(rst_b), .ce(ce),
                     .lif(lif2.lim));

  // --------------------------------------------------------------------------
  // Menu and configuration
  // --------------------------------------------------------------------------
  always_comb begin
    cfg_d     = cfg_q;
    st_d      = st_q;
    pn_d      = pn_q;
    ed_d      = ed_q;
    vw_d      = vw_q;
    clr_max   = 1'b0;
    clr_min   = 1'b0;
    clr_alarm = btn_mode;
    adj       = !cfg_q.lock;
    unique case (st_q)
      ST_INPUT: begin
        if (btn_mode && btn_up) begin
          clr_max = 1'b1;
        end else if (btn_mode && btn_down) begin
          clr_min = 1'b1;
        end else if (btn_mode) begin
          st_d = ST_TS;
          vw_d = VW_PCT;
        end else if (btn_up) begin
          vw_d = VW_MAX;
        end else if (btn_down) begin
          vw_d = VW_MIN;
        end
      end
      ST_TS: begin
        if (btn_mode) begin
          st_d = ST_SP1;
        end else if (adj) begin
          cfg_d.ts = 14'(step({2'b00, cfg_q.ts}, btn_up, btn_down,
                              16'h0000, TS_HI));
        end
      end
      ST_SP1: begin
        if (btn_mode) begin
          st_d = ST_SP2;
        end else if (adj) begin
          cfg_d.sp1 = 7'(step({9'h000, cfg_q.sp1}, btn_up, btn_down,
                              SP_LO, SP_HI));
        end
      end
      ST_SP2: begin
        if (btn_mode) begin
          st_d = ST_TR1;
        end else if (adj) begin
          cfg_d.sp2 = 7'(step({9'h000, cfg_q.sp2}, btn_up, btn_down,
                              SP_LO, SP_HI));
        end
      end
      ST_TR1: begin
        if (btn_mode) begin
          st_d = ST_TR2;
        end else if (adj) begin
          cfg_d.tr1 = step(cfg_q.tr1, btn_up, btn_down, 16'h0000, TR_HI);
        end
      end
      ST_TR2: begin
        if (btn_mode) begin
          st_d = ST_SETUP;
          pn_d = 4'h0;
        end else if (adj) begin
          cfg_d.tr2 = step(cfg_q.tr2, btn_up, btn_down, 16'h0000, TR_HI);
        end
      end
      ST_SETUP: begin
        if (btn_mode && pn_q == 4'h0) begin
          st_d = ST_INPUT;
        end else if (btn_mode) begin
          st_d = ST_EDIT;
          ed_d = par_get(cfg_q, pn_q);
        end else begin
          pn_d = 4'(step({12'h000, pn_q}, btn_up, btn_down, 16'h0000,
                         {12'h000, PAR_LAST}));
        end
      end
      ST_EDIT: begin
        if (btn_mode) begin
          st_d = ST_SETUP;
          if (adj) begin
            cfg_d = par_set(cfg_q, pn_q, ed_q);
          end
        end else if (adj) begin
          ed_d = step(ed_q, btn_up, btn_down,
                      pn_q == 4'h4 ? FS_LO : 16'h0000, par_hi(pn_q));
        end
      end
    endcase
    if (rif.wr) begin
      unique case (rif.addr)
        ADDR_CFG: begin
          cfg_d.span4    = rif.wdata[0];
          cfg_d.type1    = rif.wdata[2:1];
          cfg_d.type2    = rif.wdata[4:3];
          cfg_d.inv1     = rif.wdata[5];
          cfg_d.inv2     = rif.wdata[6];
          cfg_d.autosd   = rif.wdata[7];
          cfg_d.logic_hi = rif.wdata[8];
          cfg_d.lock     = rif.wdata[9];
        end
        ADDR_SCALE:  cfg_d.fs  = rif.wdata[7:0];
        ADDR_HYST:   {cfg_d.hys2, cfg_d.hys1} =
                       {rif.wdata[13:8], rif.wdata[5:0]};
        ADDR_SETPT:  {cfg_d.sp2, cfg_d.sp1} =
                       {rif.wdata[14:8], rif.wdata[6:0]};
        ADDR_TSTART: cfg_d.ts  = rif.wdata[13:0];
        ADDR_TREAC1: cfg_d.tr1 = rif.wdata[15:0];
        ADDR_TREAC2: cfg_d.tr2 = rif.wdata[15:0];
        default:     cfg_d     = cfg_d;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= CFG_RST;
      st_q  <= ST_INPUT;
      pn_q  <= 4'h0;
      ed_q  <= 16'h0000;
      vw_q  <= VW_PCT;
    end else if (ce) begin
      cfg_q <= cfg_d;
      st_q  <= st_d;
      pn_q  <= pn_d;
      ed_q  <= ed_d;
      vw_q  <= vw_d;
    end
  end

  // --------------------------------------------------------------------------
  // Time base, start-up timer, input and peaks
  // --------------------------------------------------------------------------
  always_comb begin
    tick     = tk_q == 18'(TICK_CYC_P - 1);
    tk_d     = tick ? 18'h0_0000 : 18'(tk_q + 18'h0_0001);
    su_d     = su_q;
    ts_cnt_d = ts_cnt_q;
    expired  = 1'b0;
    unique case (su_q)
      SU_WAIT: begin
        if (pct_q > START_PCT) begin
          su_d     = cfg_q.ts == 14'h0000 ? SU_DONE : SU_RUN;
          ts_cnt_d = 18'h0_0000;
        end
      end
      SU_RUN: begin
        if (tick) begin
          ts_cnt_d = 18'(ts_cnt_q + 18'h0_0001);
          if (ts_cnt_d >= 18'(cfg_q.ts * 18'(TS_UNIT_TICK))) begin
            su_d    = SU_DONE;
            expired = 1'b1;
          end
        end
      end
      SU_DONE: su_d = SU_DONE;
    endcase
    max_d = pct_q > max_q ? pct_q : max_q;
    min_d = pct_q < min_q ? pct_q : min_q;
    if (clr_max || expired) begin
      max_d = 8'h00;
    end
    if (clr_min || expired) begin
      min_d = 8'hFF;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tk_q     <= 18'h0_0000;
      su_q     <= SU_WAIT;
      ts_cnt_q <= 18'h0_0000;
      pct_q    <= 8'h00;
      max_q    <= 8'h00;
      min_q    <= 8'hFF;
    end else if (ce) begin
      tk_q     <= tk_d;
      su_q     <= su_d;
      ts_cnt_q <= ts_cnt_d;
      pct_q    <= pct_of(in_cur, cfg_q.span4, cfg_q.fs);
      max_q    <= max_d;
      min_q    <= min_d;
    end
  end

  // --------------------------------------------------------------------------
  // Limits and digital inputs
  // --------------------------------------------------------------------------
  assign blk_act = cfg_q.logic_hi ? alarm_block_input : !alarm_block_input;
  assign rst_act = cfg_q.logic_hi ? external_reset_input
                                  : !external_reset_input;

  assign lif1.ltype  = cfg_q.type1;
  assign lif1.setpt  = cfg_q.sp1;
  assign lif1.hyst   = cfg_q.hys1;
  assign lif1.delay  = cfg_q.tr1;
  assign lif2.ltype  = cfg_q.type2;
  assign lif2.setpt  = cfg_q.sp2;
  assign lif2.hyst   = cfg_q.hys2;
  assign lif2.delay  = cfg_q.tr2;
  assign lif1.pct    = pct_q;
  assign lif2.pct    = pct_q;
  assign lif1.tick   = tick;
  assign lif2.tick   = tick;
  assign lif1.mon_en = su_q != SU_RUN;
  assign lif2.mon_en = su_q != SU_RUN;
  assign lif1.autosd = cfg_q.autosd;
  assign lif2.autosd = cfg_q.autosd;
  assign lif1.block  = blk_act;
  assign lif2.block  = blk_act;
  assign lif1.clear  = clr_alarm || rst_act;
  assign lif2.clear  = clr_alarm || rst_act;

  // --------------------------------------------------------------------------
  // Outputs and register read
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (st_q)
      ST_INPUT: dv_d = {8'h00, vw_q == VW_MAX ? max_q :
                               vw_q == VW_MIN ? min_q : pct_q};
      ST_TS:    dv_d = {2'b00, cfg_q.ts};
      ST_SP1:   dv_d = {9'h000, cfg_q.sp1};
      ST_SP2:   dv_d = {9'h000, cfg_q.sp2};
      ST_TR1:   dv_d = cfg_q.tr1;
      ST_TR2:   dv_d = cfg_q.tr2;
      ST_SETUP: dv_d = {12'h000, pn_q};
      ST_EDIT:  dv_d = ed_q;
    endcase
    rif.hit   = 1'b1;
    rif.rdata = 32'h0000_0000;
    unique case (rif.addr)
      ADDR_CFG:    rif.rdata[9:0] = {cfg_q.lock, cfg_q.logic_hi,
                     cfg_q.autosd, cfg_q.inv2, cfg_q.inv1, cfg_q.type2,
                     cfg_q.type1, cfg_q.span4};
      ADDR_SCALE:  rif.rdata[7:0]  = cfg_q.fs;
      ADDR_HYST:   rif.rdata[13:0] = {cfg_q.hys2, 2'b00, cfg_q.hys1};
      ADDR_SETPT:  rif.rdata[14:0] = {cfg_q.sp2, 1'b0, cfg_q.sp1};
      ADDR_TSTART: rif.rdata[13:0] = cfg_q.ts;
      ADDR_TREAC1: rif.rdata[15:0] = cfg_q.tr1;
      ADDR_TREAC2: rif.rdata[15:0] = cfg_q.tr2;
      ADDR_STATUS: rif.rdata[13:0] = {led_q, su_q == SU_RUN, rly2_q,
                     rly1_q, lif2.alarm, lif1.alarm, pct_q};
      ADDR_PEAK:   rif.rdata[15:0] = {min_q, max_q};
      default:     rif.hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rly1_q <= 1'b0;
      rly2_q <= 1'b0;
      led_q  <= 1'b0;
      dv_q   <= 16'h0000;
    end else if (ce) begin
      rly1_q <= lif1.alarm ^ cfg_q.inv1;
      rly2_q <= lif2.alarm ^ cfg_q.inv2;
      led_q  <= st_q == ST_SETUP || st_q == ST_EDIT;
      dv_q   <= dv_d;
    end
  end

  assign relay1    = rly1_q;
  assign relay2    = rly2_q;
  assign setup_led = led_q;
  assign disp_sel  = st_q;
  assign disp_val  = dv_q;

endmodule : dlam_top

/* File: test/dlam_top_properties.sv */
`timescale 1ns/100ps

module dlam_top_check (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        btn_mode,
  input wire logic        btn_up,
  input wire logic        btn_down,
  input wire logic        setup_led,
  input wire logic [2:0]  disp_sel,
  input wire logic [15:0] disp_val
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wire logic q = !btn_up && !btn_down;
  wire logic m = ce && btn_mode && q;
  hold_menu_a: assert property (!btn_mode && q |=> $stable(disp_sel))
    else $error("menu state moved without a press");
  step_menu_a: assert property (m && disp_sel < 3'h6
    |=> disp_sel == $past(disp_sel) + 3'h1) else $error("mode step wrong");
  setup_led_a: assert property ($past(ce)
    |-> setup_led == ($past(disp_sel) >= 3'h6))
    else $error("setup light wrong");
  open_slot_a: assert property (m && disp_sel == 3'h6
    && $past(disp_sel) == 3'h6 && !$past(btn_up || btn_down)
    && disp_val != 16'h0000 |=> disp_sel == 3'h7) else $error("no edit");
  exit_menu_a: assert property (m && disp_sel == 3'h6
    && $past(disp_sel) == 3'h6 && !$past(btn_up || btn_down)
    && disp_val == 16'h0000 |=> disp_sel == 3'h0) else $error("no exit");
  store_value_a: assert property (m && disp_sel == 3'h7
    |=> disp_sel == 3'h6) else $error("store did not return");
  menu_stay_a: assert property (!btn_mode && disp_sel[2:1] == 2'b11
    |=> $stable(disp_sel)) else $error("menu left on up or down");
  peak_clear_a: assert property (ce && btn_mode && !q
    && disp_sel == 3'h0 |=> disp_sel == 3'h0) else $error("view moved");
endmodule : dlam_top_check

bind dlam_top dlam_top_check u_chk (.*);

/* File: test/dlam_field.sv */
`timescale 1ns/100ps

module dlam_field (
  input  wire logic core_clk,
  input  wire logic blk,
  input  wire logic clr,
  input  wire logic hi,
  output logic      alarm_block_input = 1'b1,
  output logic      external_reset_input = 1'b1
);
  // The pins start high, the idle level of the active-low default; hi
  // selects active-high drive once the block is set to that polarity.
  always @(posedge core_clk) begin
    alarm_block_input    <= hi ? blk : !blk;
    external_reset_input <= hi ? clr : !clr;
  end
endmodule : dlam_field

/* File: test/dlam_top_tb.sv */
`timescale 1ns/100ps

module dlam_top_tb
  import dlam_pkg::*;
;
  logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, btn_mode = 1'b0, btn_up = 1'b0, btn_down = 1'b0;
  logic blk = 1'b0, clr = 1'b0, hi = 1'b0, e;
  logic [7:0] paddr = 8'h00, in_cur = 8'h64;
  logic [31:0] pwdata = 32'h0000_0000, prdata, v;
  logic pready, pslverr, relay1, relay2, setup_led;
  logic alarm_block_input, external_reset_input;
  logic [2:0] disp_sel;
  logic [15:0] disp_val;
  logic [31:0] dv [7] = '{32'h0000_000C, 32'h0000_00C8, 32'h0000_0000,
      32'h0000_1450, 32'h0000_0014, 32'h0000_000A, 32'h0000_0064};
  int failures = 0;
  int checks = 0;
  always #20 core_clk = !core_clk;
  dlam_top #(.TICK_CYC_P(10)) u_dut (.ce(1'b1), .*);
  dlam_field u_fld (.core_clk, .blk, .clr, .hi, .alarm_block_input,
      .external_reset_input);
  task chk(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: unexpected value", $time);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(v === x);
  endtask : rd
  task press(input logic m, input logic u, input logic d);
    @(posedge core_clk);
    {btn_mode, btn_up, btn_down} <= {m, u, d};
    @(posedge core_clk);
    {btn_mode, btn_up, btn_down} <= 3'b000;
    repeat (3) @(posedge core_clk);
  endtask : press
  task r1(input logic x, input int n);
    repeat (n) if (relay1 !== x) @(posedge core_clk);
    chk(relay1 === x);
  endtask : r1
  task end_of_test;
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (30000) @(posedge core_clk);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) rd(8'(i * 4), dv[i]);
    rd(8'h40, 32'h0000_0000);
    chk(e === 1'b1);
    in_cur <= 8'hAA;
    repeat (500) @(posedge core_clk);
    chk(relay1 === 1'b0);
    r1(1'b1, 2500);
    rd(ADDR_PEAK, 32'h0000_5555);
    in_cur <= 8'h64;
    repeat (20) @(posedge core_clk);
    chk(relay1 === 1'b1);
    press(1'b1, 1'b1, 1'b0);
    rd(ADDR_PEAK, 32'h0000_3232);
    chk(relay1 === 1'b0);
    in_cur <= 8'hAA;
    repeat (60) @(posedge core_clk);
    in_cur <= 8'h64;
    repeat (4) @(posedge core_clk);
    in_cur <= 8'hAA;
    repeat (80) @(posedge core_clk);
    chk(relay1 === 1'b0);
    r1(1'b1, 60);
    in_cur <= 8'h64;
    clr <= 1'b1;
    repeat (8) @(posedge core_clk);
    clr <= 1'b0;
    chk(relay1 === 1'b0);
    blk <= 1'b1;
    in_cur <= 8'hAA;
    repeat (200) @(posedge core_clk);
    chk(relay1 === 1'b0);
    blk <= 1'b0;
    r1(1'b1, 200);
    apb(1'b1, ADDR_CFG, 32'h0000_002C);
    r1(1'b0, 8);
    in_cur <= 8'h64;
    repeat (2) press(1'b1, 1'b0, 1'b0);
    apb(1'b1, ADDR_CFG, 32'h0000_020C);
    press(1'b0, 1'b1, 1'b0);
    rd(ADDR_SETPT, 32'h0000_1450);
    apb(1'b1, ADDR_CFG, 32'h0000_000C);
    press(1'b0, 1'b1, 1'b0);
    rd(ADDR_SETPT, 32'h0000_1451);
    repeat (4) press(1'b1, 1'b0, 1'b0);
    chk(setup_led === 1'b1 && disp_sel === 3'h6);
    press(1'b0, 1'b1, 1'b0);
    press(1'b1, 1'b0, 1'b0);
    press(1'b0, 1'b1, 1'b0);
    press(1'b1, 1'b0, 1'b0);
    rd(ADDR_CFG, 32'h0000_000D);
    press(1'b0, 1'b0, 1'b1);
    press(1'b1, 1'b0, 1'b0);
    chk(disp_sel === 3'h0);
    chk(disp_val === 16'h0025);
    press(1'b0, 1'b1, 1'b0);
    chk(disp_val === 16'h0055);
    apb(1'b1, ADDR_CFG, 32'h0000_008D);
    in_cur <= 8'h00;
    repeat (1100) @(posedge core_clk);
    chk(relay2 === 1'b0);
    apb(1'b1, ADDR_CFG, 32'h0000_000D);
    repeat (900) @(posedge core_clk);
    chk(relay2 === 1'b0);
    repeat (200) @(posedge core_clk);
    chk(relay2 === 1'b1);
    apb(1'b1, ADDR_HYST, 32'h0000_0005);
    apb(1'b1, ADDR_CFG, 32'h0000_010D);
    hi <= 1'b1;
    in_cur <= 8'hC8;
    r1(1'b1, 200);
    in_cur <= 8'hA5;
    repeat (20) @(posedge core_clk);
    chk(relay1 === 1'b1);
    in_cur <= 8'h64;
    r1(1'b0, 8);
    in_cur <= 8'hC8;
    blk <= 1'b1;
    repeat (200) @(posedge core_clk);
    chk(relay1 === 1'b0);
    {blk, hi, in_cur} <= 10'h000;
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b1, ADDR_TSTART, 32'h0000_0000);
    in_cur <= 8'hC8;
    r1(1'b1, 150);
    end_of_test;
  end
endmodule : dlam_top_tb
